/* File: common/sfg_pkg.sv */
// Constants for the stepper fault guard: timing, register map, fields, level codes
package sfg_pkg;

    // ----------------------------------------------------------------
    // Clock and masking times
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 40;        // ref_clk at 25 MHz
    localparam int unsigned OSC_FREQ_KHZ = 6400;       // system_osc nominal rate
    localparam int unsigned THERM_MASK_OSC = 32;       // thermal mask in system_osc cycles
    localparam int unsigned OVC_MASK_OSC = 8;          // over-current mask in system_osc cycles
    localparam int unsigned THERM_MASK_NS = THERM_MASK_OSC * 1000000 / OSC_FREQ_KHZ;
    localparam int unsigned OVC_MASK_NS = OVC_MASK_OSC * 1000000 / OSC_FREQ_KHZ;
    // Least times round up to whole ref_clk cycles
    localparam int unsigned THERM_MASK_CYC = (THERM_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OVC_MASK_CYC = (OVC_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MASK_CNT_W = 8;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] LEVEL_OFF = 12'h008;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // CTRL fields
    localparam int unsigned CTRL_STBY_BIT = 0;

    // STATUS fields
    localparam int unsigned ST_THERM_BIT = 0;
    localparam int unsigned ST_OVC_BIT = 1;
    localparam int unsigned ST_OFF_BIT = 2;
    localparam int unsigned ST_TDET_BIT = 3;
    localparam int unsigned ST_ODET_BIT = 4;
    localparam int unsigned ST_STBY_BIT = 5;
    localparam int unsigned ST_SUPPLY_BIT = 6;

    // LEVEL fields
    localparam int unsigned RATIO_W = 7;
    localparam int unsigned LV_RATIO_A_LSB = 0;
    localparam int unsigned LV_RATIO_B_LSB = 8;
    localparam int unsigned LV_CODE_A_LSB = 16;
    localparam int unsigned LV_CODE_B_LSB = 18;

    // ----------------------------------------------------------------
    // Current level codes {bit, bit_hi} and chopping ratios in percent
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SFG_LVL_ZERO = 2'b00,
        SFG_LVL_LOW = 2'b01,
        SFG_LVL_MID = 2'b10,
        SFG_LVL_FULL = 2'b11
    } sfg_level_t;

    localparam logic [6:0] RATIO_FULL = 7'h64;   // 100 percent
    localparam logic [6:0] RATIO_MID = 7'h47;    // 71 percent
    localparam logic [6:0] RATIO_LOW = 7'h26;    // 38 percent
    localparam logic [6:0] RATIO_ZERO = 7'h00;   // 0 percent

    // Synchroniser vector layout
    localparam int unsigned SY_W = 8;
    localparam int unsigned SY_TDET = 0;
    localparam int unsigned SY_ODET = 1;
    localparam int unsigned SY_STBY = 2;
    localparam int unsigned SY_SUPPLY = 3;
    localparam int unsigned SY_LVL_LSB = 4;      // bits [7:4]: {hi_b, lo_b, hi_a, lo_a}

endpackage

/* File: verif/sfg_ctrl_model.sv */
// Motor controller model driving the current level and standby pins
`timescale 1ns/1ps
module sfg_ctrl_model (
    // Clock
    input wire logic ref_clk,
    // Setup pins toward the driver
    output logic [1:0] current_level_bits,
    output logic [1:0] current_level_bits_hi,
    output logic standby_pin
);
    // Pins idle at zero current, out of standby
    initial begin
        current_level_bits = 2'h0;
        current_level_bits_hi = 2'h0;
        standby_pin = 1'b0;
    end

    // Level code per channel is {bits, bits_hi}; lines change just after an edge
    task set_code(input logic [1:0] code_a, input logic [1:0] code_b);
        @(posedge ref_clk);
        current_level_bits <= {code_b[1], code_a[1]};
        current_level_bits_hi <= {code_b[0], code_a[0]};
    endtask

    // Standby request, held until changed again
    task set_standby(input logic s);
        @(posedge ref_clk);
        standby_pin <= s;
    endtask
endmodule

/* File: verif/test_stepper_fault_guard.sv */
// Testbench for the stepper fault guard: registers, trips, clears, level decode
`timescale 1ns/1ps
module test_stepper_fault_guard;
    import sfg_pkg::*;
    logic ref_clk, rstn, psel, penable, pwrite, motor_supply_ok, pready, pslverr, err;
    logic outputs_off, fault_flag_out, standby_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] det_drv, current_level_bits, current_level_bits_hi;
    logic [6:0] chop_ratio_a, chop_ratio_b;
    int fails, checks_done;

    // ----------------------------------------------------------------
    // Design and far-side model
    // ----------------------------------------------------------------
    sfg_top i_sfg_top (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .thermal_det(det_drv[0]), .overcurrent_det(det_drv[1]),
        .motor_supply_ok(motor_supply_ok), .standby_pin(standby_pin),
        .current_level_bits(current_level_bits), .current_level_bits_hi(current_level_bits_hi),
        .outputs_off(outputs_off), .fault_flag_out(fault_flag_out),
        .chop_ratio_a(chop_ratio_a), .chop_ratio_b(chop_ratio_b));
    sfg_ctrl_model i_sfg_ctrl_model (.ref_clk(ref_clk), .current_level_bits(current_level_bits),
        .current_level_bits_hi(current_level_bits_hi), .standby_pin(standby_pin));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Verdict and end of run
    task summarize;
        if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One comparison, counted
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // APB transfer: setup, access held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        #1;
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                chk("apb_timeout", 0, 1);
                summarize();
            end
            @(posedge ref_clk);
            #1;
        end
        rd = prdata;
        err = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Detector pulse one cycle short of its mask: must not trip
    task glitch(input int sel, input int len);
        @(posedge ref_clk);
        det_drv[sel] <= 1'b1;
        repeat (len) @(posedge ref_clk);
        det_drv[sel] <= 1'b0;
        repeat (12) @(posedge ref_clk);
        #1;
        chk("no_trip", 0, {31'h0, outputs_off});
    endtask

    // Detector held high: count edges until the outputs are forced off
    task trip(input int sel, input int exp);
        int n;
        n = 0;
        @(posedge ref_clk);
        det_drv[sel] <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            #1;
        end while (outputs_off !== 1'b1 && n < 300);
        chk("trip_cycles", exp, n);
        chk("fault_flag_set", 1, {31'h0, fault_flag_out});
        @(posedge ref_clk);
        det_drv[sel] <= 1'b0;
    endtask

    // Wait for a clear to pass the synchronisers, then expect no trip
    task cleared;
        repeat (5) @(posedge ref_clk);
        #1;
        chk("outputs_off_clr", 0, {31'h0, outputs_off});
        chk("fault_flag_clr", 0, {31'h0, fault_flag_out});
    endtask

    // Expected ratio for a {bits, bits_hi} code
    function automatic logic [6:0] ratio_of(input logic [1:0] c);
        case (c)
            2'b11: return RATIO_FULL;
            2'b10: return RATIO_MID;
            2'b01: return RATIO_LOW;
            default: return RATIO_ZERO;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Clock and main sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        logic [1:0] ca, cb;
        rstn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        det_drv = 2'h0;
        motor_supply_ok = 1'b1;
        fails = 0;
        checks_done = 0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk("ctrl_reset", CTRL_RST, rd);
        apb(1'b1, STATUS_OFF, 32'hffff_ffff);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("status_idle", 32'h0000_0040, rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped_err", 1, {31'h0, err});
        chk("unmapped_data", 0, rd);
        for (int i = 0; i < 4; i++) begin
            ca = 2'(i);
            cb = 2'(3 - i);
            i_sfg_ctrl_model.set_code(ca, cb);
            repeat (4) @(posedge ref_clk);
            #1;
            chk("ratio_a", {25'h0, ratio_of(ca)}, {25'h0, chop_ratio_a});
            chk("ratio_b", {25'h0, ratio_of(cb)}, {25'h0, chop_ratio_b});
            apb(1'b0, LEVEL_OFF, 32'h0);
            chk("level_reg", {12'h0, cb, ca, 1'b0, ratio_of(cb), 1'b0, ratio_of(ca)}, rd);
        end
        glitch(1, OVC_MASK_CYC - 1);
        trip(1, OVC_MASK_CYC + 4);
        i_sfg_ctrl_model.set_code(2'b01, 2'b10);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("ovc_held", 32'h0000_0046, rd);
        chk("flag_held", 1, {31'h0, fault_flag_out});
        apb(1'b1, CTRL_OFF, 32'h0000_0001);
        cleared();
        apb(1'b1, CTRL_OFF, 32'h0);
        glitch(0, THERM_MASK_CYC - 1);
        trip(0, THERM_MASK_CYC + 4);
        repeat (20) @(posedge ref_clk);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("therm_held", 32'h0000_0045, rd);
        i_sfg_ctrl_model.set_standby(1'b1);
        cleared();
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("status_stby", 32'h0000_0060, rd);
        i_sfg_ctrl_model.set_standby(1'b0);
        repeat (5) @(posedge ref_clk);
        trip(0, THERM_MASK_CYC + 4);
        motor_supply_ok <= 1'b0;
        cleared();
        @(posedge ref_clk);
        motor_supply_ok <= 1'b1;
        repeat (5) @(posedge ref_clk);
        trip(1, OVC_MASK_CYC + 4);
        motor_supply_ok <= 1'b0;
        cleared();
        summarize();
    end
endmodule

/* File: verilog/sfg_mask_counter.sv */
// Detector qualifier: counts consecutive asserted cycles up to a limit
`timescale 1ns/1ps
module sfg_mask_counter #(
    parameter int unsigned LIMIT = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Detector level, already synchronised
    input wire logic det,
    // Count and qualified level
    output logic [sfg_pkg::MASK_CNT_W-1:0] cnt,
    output logic qual
);
    import sfg_pkg::*;

    localparam logic [MASK_CNT_W-1:0] LIM = MASK_CNT_W'(LIMIT);

    logic [MASK_CNT_W-1:0] cnt_r;

    // Any drop of the detector restarts the interval, so short noise is rejected
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (!det) begin
            cnt_r <= '0;
        end else if (cnt_r != LIM) begin
            cnt_r <= cnt_r + MASK_CNT_W'(1);
        end
    end

    assign cnt = cnt_r;
    assign qual = (cnt_r == LIM);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    cnt_step_a: assert property (det && cnt_r != LIM |=> cnt_r == $past(cnt_r) + MASK_CNT_W'(1))
        else $error("mask count did not advance");
    cnt_drop_a: assert property (!det |=> cnt_r == '0)
        else $error("mask count not restarted");

endmodule

/* File: verilog/sfg_top.sv */
// Stepper fault guard: fault masking, trip latches, level decode, APB registers
//
// Functional notes
// - Thermal detection trips and turns outputs off
// - Thermal trip held until standby or supply loss
// - Over-current detection trips and turns outputs off
// - Over-current trip held until standby or supply loss
// - Thermal detector must persist 32 oscillator cycles
// - Over-current detector must persist 8 oscillator cycles
// - Level bits decode to 100/71/38/0 percent
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module sfg_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sfg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Detector and supply pins
    input wire logic thermal_det,
    input wire logic overcurrent_det,
    input wire logic motor_supply_ok,
    input wire logic standby_pin,
    // Current level pins, bit 0 channel A, bit 1 channel B
    input wire logic [1:0] current_level_bits,
    input wire logic [1:0] current_level_bits_hi,
    // Output stage control and status
    output logic outputs_off,
    output logic fault_flag_out,
    output logic [sfg_pkg::RATIO_W-1:0] chop_ratio_a,
    output logic [sfg_pkg::RATIO_W-1:0] chop_ratio_b
);
    import sfg_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [SY_W-1:0] sync1_r;
    logic [SY_W-1:0] sync2_r;
    logic tdet_s;
    logic odet_s;
    logic stby_s;
    logic supply_s;
    logic clear_s;
    logic [MASK_CNT_W-1:0] therm_cnt;
    logic [MASK_CNT_W-1:0] ovc_cnt;
    logic therm_qual;
    logic ovc_qual;
    logic thermal_trip_r;
    logic overcurrent_trip_r;
    logic outputs_off_r;
    logic fault_flag_r;
    logic [1:0] code_s [2];
    logic [RATIO_W-1:0] ratio_r [2];
    logic [31:0] ctrl_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic hit_nxt;
    logic apb_done;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops on every detector, supply, standby and level pin before any logic looks at it; the APB pins are not synchronised
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {current_level_bits_hi[1], current_level_bits[1],
                        current_level_bits_hi[0], current_level_bits[0],
                        motor_supply_ok, standby_pin, overcurrent_det, thermal_det};
            sync2_r <= sync1_r;
        end
    end

    assign tdet_s = sync2_r[SY_TDET];
    assign odet_s = sync2_r[SY_ODET];
    assign stby_s = sync2_r[SY_STBY];
    assign supply_s = sync2_r[SY_SUPPLY];
    assign code_s[0] = {sync2_r[SY_LVL_LSB], sync2_r[SY_LVL_LSB+1]};
    assign code_s[1] = {sync2_r[SY_LVL_LSB+2], sync2_r[SY_LVL_LSB+3]};

    // Standby (pin or software) or an absent supply holds the latches clear
    assign clear_s = stby_s | ctrl_r[CTRL_STBY_BIT] | ~supply_s;

    // ----------------------------------------------------------------
    // Detector masking
    // ----------------------------------------------------------------
    // thermal masking interval
    sfg_mask_counter #(
        .LIMIT(THERM_MASK_CYC)
    ) u_therm_mask (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .det(tdet_s),
        .cnt(therm_cnt),
        .qual(therm_qual)
    );

    sfg_mask_counter #(
        .LIMIT(OVC_MASK_CYC)
    ) u_ovc_mask (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .det(odet_s),
        .cnt(ovc_cnt),
        .qual(ovc_qual)
    );

    // ----------------------------------------------------------------
    // Trip latches
    // ----------------------------------------------------------------
    // thermal latch, cleared only by standby or supply loss
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            thermal_trip_r <= 1'b0;
        end else if (clear_s) begin
            thermal_trip_r <= 1'b0;
        end else if (therm_qual) begin
            thermal_trip_r <= 1'b1;
        end
    end

    // over-current latch, cleared only by standby or supply loss
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            overcurrent_trip_r <= 1'b0;
        end else if (clear_s) begin
            overcurrent_trip_r <= 1'b0;
        end else if (ovc_qual) begin
            overcurrent_trip_r <= 1'b1;
        end
    end

    // output stage forced off by either trip
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outputs_off_r <= 1'b0;
        end else begin
            outputs_off_r <= thermal_trip_r | overcurrent_trip_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fault_flag_r <= 1'b0;
        end else begin
            fault_flag_r <= thermal_trip_r | overcurrent_trip_r;
        end
    end

    // ----------------------------------------------------------------
    // Current level decode, one per channel
    // ----------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_level
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                ratio_r[ch] <= RATIO_ZERO;
            end else begin
                case (code_s[ch])
                    SFG_LVL_FULL: ratio_r[ch] <= RATIO_FULL;
                    SFG_LVL_MID: ratio_r[ch] <= RATIO_MID;
                    SFG_LVL_LOW: ratio_r[ch] <= RATIO_LOW;
                    default: ratio_r[ch] <= RATIO_ZERO;
                endcase
            end
        end

        lvl_full_a: assert property (@(posedge ref_clk) disable iff (!rstn)
            code_s[ch] == SFG_LVL_FULL |=> ratio_r[ch] == 7'h64)
            else $error("full level not decoded to 100");
        lvl_mid_a: assert property (@(posedge ref_clk) disable iff (!rstn)
            code_s[ch] == SFG_LVL_MID |=> ratio_r[ch] == 7'h47)
            else $error("mid level not decoded to 71");
        lvl_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
            code_s[ch] == SFG_LVL_LOW |=> ratio_r[ch] == 7'h26)
            else $error("low level not decoded to 38");
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Access phase lasts two cycles; the transfer ends when pready is seen high
    assign apb_done = psel & penable & pready_r;
    assign hit_nxt = (paddr == CTRL_OFF) | (paddr == STATUS_OFF) | (paddr == LEVEL_OFF);

    // Read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            CTRL_OFF: rdata_nxt = ctrl_r;
            STATUS_OFF: begin
                rdata_nxt[ST_THERM_BIT] = thermal_trip_r;
                rdata_nxt[ST_OVC_BIT] = overcurrent_trip_r;
                rdata_nxt[ST_OFF_BIT] = outputs_off_r;
                rdata_nxt[ST_TDET_BIT] = tdet_s;
                rdata_nxt[ST_ODET_BIT] = odet_s;
                rdata_nxt[ST_STBY_BIT] = stby_s;
                rdata_nxt[ST_SUPPLY_BIT] = supply_s;
            end
            LEVEL_OFF: begin
                rdata_nxt[LV_RATIO_A_LSB +: RATIO_W] = ratio_r[0];
                rdata_nxt[LV_RATIO_B_LSB +: RATIO_W] = ratio_r[1];
                rdata_nxt[LV_CODE_A_LSB +: 2] = code_s[0];
                rdata_nxt[LV_CODE_B_LSB +: 2] = code_s[1];
            end
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Handshake, read data and error answer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~hit_nxt;
            if (psel && penable && !pready_r) begin
                prdata_r <= rdata_nxt;
            end
        end
    end

    // Control register, only the standby bit is writable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
        end else if (apb_done && pwrite && paddr == CTRL_OFF) begin
            ctrl_r[CTRL_STBY_BIT] <= pwdata[CTRL_STBY_BIT];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign outputs_off = outputs_off_r;
    assign fault_flag_out = fault_flag_r;
    assign chop_ratio_a = ratio_r[0];
    assign chop_ratio_b = ratio_r[1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_trip_set;
        !thermal_trip_r ##1 thermal_trip_r;
    endsequence

    sequence s_ovc_set;
        !overcurrent_trip_r ##1 overcurrent_trip_r;
    endsequence

    sequence s_apb_wait;
        psel && penable && !pready_r;
    endsequence

    therm_off_a: assert property (s_trip_set |=> outputs_off_r && fault_flag_r)
        else $error("thermal trip did not turn outputs off");
    therm_hold_a: assert property (thermal_trip_r && !clear_s |=> thermal_trip_r)
        else $error("thermal latch dropped without clear");
    ovc_off_a: assert property (s_ovc_set |=> outputs_off_r)
        else $error("over-current trip did not turn outputs off");
    ovc_hold_a: assert property (overcurrent_trip_r && !clear_s |=> overcurrent_trip_r)
        else $error("over-current latch dropped without clear");
    therm_mask_a: assert property (s_trip_set |-> $past(therm_cnt) == MASK_CNT_W'(THERM_MASK_CYC))
        else $error("thermal trip before full mask interval");
    ovc_mask_a: assert property (s_ovc_set |-> $past(ovc_cnt) == MASK_CNT_W'(OVC_MASK_CYC))
        else $error("over-current trip before full mask interval");
    flag_clear_a: assert property (clear_s ##1 !therm_qual && !ovc_qual
        |=> !fault_flag_r)
        else $error("fault flag stuck after clear");
    apb_ready_a: assert property (s_apb_wait |=> pready_r ##1 !pready_r)
        else $error("APB answer not one cycle after access");

endmodule
